// ---- fabric_model.sv ----
// routing fabric and interrupt logic seen from the timer
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  input wire logic clock_in, // clock
  input wire logic resetn_in, // reset
  input wire timer_counter_pwm_pkg::chan_ctl_t [3:0] req_in, // wanted controls
  input wire timer_counter_pwm_pkg::chan_status_t [3:0] status_in, // timer state
  output timer_counter_pwm_pkg::chan_ctl_t [3:0] ctl_out, // controls
  output logic [3:0][7:0] irq_count_out // irq pulses seen
);
  import timer_counter_pwm_pkg::*;
  // controls move only on edges, one cycle late, as real routing would
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctl_out <= '0;
      irq_count_out <= '0;
    end else begin
      ctl_out <= req_in;
      for (int i = 0; i < NUM_CH; i++) begin
        irq_count_out[i] <= irq_count_out[i] + 8'(status_in[i].irq);
      end
    end
  end
endmodule : fabric_model
`default_nettype wire

// ---- tick_sync.sv ----
// three-stage synchroniser for an external tick pin, with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module tick_sync (
  input wire logic clock_in,   // system clock
  input wire logic resetn_in,  // async reset, active low
  input wire logic pin_in,     // asynchronous pin
  output logic rise_out        // one-cycle pulse per rising edge
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;       // pin level once two stages agree
    logic rise;
  } sync_state_t;

  sync_state_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stage = {state_reg.stage[1:0], pin_in};
    // a change only counts once the second and third stages agree
    if (state_reg.stage[2] == state_reg.stage[1]) begin
      state_next.level = state_reg.stage[2];
    end
    state_next.rise = state_next.level & ~state_reg.level;
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // the first stage is looked at by nothing but the second
  assign rise_out = state_reg.rise;
endmodule : tick_sync
`default_nettype wire

// ---- timer_counter_pwm_16bit.sv ----
// four-channel 16-bit down-counting timer, counter and pwm unit
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_16bit (
  input wire logic clock_in,                                               // 20 MHz system clock
  input wire logic resetn_in,                                              // async reset, active low
  input wire timer_counter_pwm_pkg::chan_cfg_t [3:0] cfg_in,              // per-channel configuration
  input wire timer_counter_pwm_pkg::chan_ctl_t [3:0] ctl_in,              // fabric control inputs
  input wire logic [3:0] ext_tick_in,                                      // external count clocks (pins)
  output timer_counter_pwm_pkg::chan_status_t [3:0] status_out            // per-channel state and outputs
);
  import timer_counter_pwm_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] capture;
    logic run_prev;
    logic cap_prev;
    logic running;
    logic tc_flag;
    logic raw_prev;
    logic [DB_W-1:0] db_cnt;
    logic cmp_q;
    logic tc_q;
    logic irq_q;
  } chan_state_t;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    chan_state_t [NUM_CH-1:0] ch;
  } top_state_t;

  top_state_t state_reg, state_next;
  logic [NUM_CH-1:0] ext_rise;

  // pin clocks come from outside the clock domain
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_sync
      tick_sync u_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .pin_in(ext_tick_in[gi]),
        .rise_out(ext_rise[gi])
      );
    end
  endgenerate

  function automatic logic cmp_eval(input logic [2:0] sel, input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] val);
    logic r;
    r = 1'b0;
    case (sel)
      CMP_LESS: r = cnt < val;
      CMP_LESS_EQUAL: r = cnt <= val;
      CMP_EQUAL: r = cnt == val;
      CMP_GREATER_EQUAL: r = cnt >= val;
      CMP_GREATER: r = cnt > val;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : cmp_eval

  always_comb begin
    logic tick_div4;
    logic tick_div64;
    logic tick;
    logic start;
    logic advance;
    logic cap_edge;
    logic raw;
    logic settled;
    logic tc_rise;
    logic cmp_rise;
    logic [CNT_W-1:0] dec;
    chan_state_t c;
    chan_state_t n;
    tick_div4 = 1'b0;
    tick_div64 = 1'b0;
    tick = 1'b0;
    start = 1'b0;
    advance = 1'b0;
    cap_edge = 1'b0;
    raw = 1'b0;
    settled = 1'b0;
    tc_rise = 1'b0;
    cmp_rise = 1'b0;
    dec = '0;
    c = '0;
    n = '0;
    state_next = state_reg;
    // shared prescaler gives one-cycle enables, never derived clocks
    state_next.div = state_reg.div + 6'h01;
    tick_div4 = (state_reg.div & DIV4_MASK) == DIV4_LAST;
    tick_div64 = state_reg.div == DIV64_LAST;
    for (int i = 0; i < NUM_CH; i++) begin
      c = state_reg.ch[i];
      n = c;
      case (cfg_in[i].clk_sel)
        CLK_SEL_SYS: tick = 1'b1;
        CLK_SEL_DIV4: tick = tick_div4;
        CLK_SEL_DIV64: tick = tick_div64;
        default: tick = ext_rise[i];
      endcase
      n.run_prev = cfg_in[i].run;
      start = cfg_in[i].run & ~c.run_prev;
      // gated mode stalls while the fabric enable is low
      advance = tick & c.running &
                ((cfg_in[i].mode != MODE_GATED) | ctl_in[i].enable);
      dec = c.count - 16'h0001;
      if (!cfg_in[i].run) begin
        n.running = 1'b0;
        n.tc_flag = 1'b0;
      end else if (start || ctl_in[i].reset) begin
        n.count = cfg_in[i].period;
        n.running = 1'b1;
        n.tc_flag = 1'b0;
      end else if (advance) begin
        if (c.count == CNT_RESET) begin
          n.count = cfg_in[i].period;
        end else begin
          n.count = dec;
        end
        // flag lives from the tick that reaches zero to the next tick
        n.tc_flag = (c.count != CNT_RESET) && (dec == CNT_RESET);
        if (n.tc_flag && cfg_in[i].mode == MODE_ONESHOT) begin
          n.running = 1'b0;
        end
      end else if (tick) begin
        n.tc_flag = 1'b0;
      end
      // capture on rising edge of the fabric capture input
      n.cap_prev = ctl_in[i].capture;
      cap_edge = ctl_in[i].capture & ~c.cap_prev;
      if (cap_edge) begin
        n.capture = c.count;
      end
      raw = cfg_in[i].run & cmp_eval(cfg_in[i].cmp_mode, c.count, cfg_in[i].compare);
      n.raw_prev = raw;
      // dead time restarts on every compare transition
      if (raw != c.raw_prev) begin
        n.db_cnt = cfg_in[i].deadband;
      end else if (c.db_cnt != '0) begin
        n.db_cnt = c.db_cnt - 8'h01;
      end
      // dead time lasts exactly the programmed number of clocks, none when zero
      settled = (n.db_cnt == '0);
      if (ctl_in[i].kill) begin
        n.cmp_q = 1'b0;
      end else if (cfg_in[i].compl_en) begin
        n.cmp_q = raw & settled;
      end else begin
        n.cmp_q = raw;
      end
      if (cfg_in[i].compl_en) begin
        n.tc_q = ~ctl_in[i].kill & cfg_in[i].run & ~raw & settled;
      end else begin
        n.tc_q = n.tc_flag;
      end
      tc_rise = n.tc_flag & ~c.tc_flag;
      cmp_rise = raw & ~c.raw_prev;
      n.irq_q = (tc_rise & cfg_in[i].irq_mask[IRQ_TC_BIT]) |
                (cmp_rise & cfg_in[i].irq_mask[IRQ_CMP_BIT]) |
                (cap_edge & cfg_in[i].irq_mask[IRQ_CAP_BIT]);
      state_next.ch[i] = n;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output comes from a register; the count is read straight off the counter
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      status_out[i].count = state_reg.ch[i].count;
      status_out[i].capture = state_reg.ch[i].capture;
      status_out[i].running = state_reg.ch[i].running;
      status_out[i].cmp = state_reg.ch[i].cmp_q;
      status_out[i].tc = state_reg.ch[i].tc_q;
      status_out[i].irq = state_reg.ch[i].irq_q;
    end
  end
endmodule : timer_counter_pwm_16bit
`default_nettype wire

// ---- timer_counter_pwm_16bit_asserts.sv ----
// channel 0 assertions for the timer unit, plus one channel 3 complementary-output check
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_16bit_asserts (
  input wire logic clock_in, // clock
  input wire logic resetn_in, // reset
  input wire timer_counter_pwm_pkg::chan_cfg_t [3:0] cfg_in, // config
  input wire timer_counter_pwm_pkg::chan_ctl_t [3:0] ctl_in, // controls
  input wire logic [3:0] ext_tick_in, // ticks
  input wire timer_counter_pwm_pkg::chan_status_t [3:0] status_out // state
);
  import timer_counter_pwm_pkg::*;
  chan_cfg_t c;
  chan_ctl_t k;
  chan_status_t s;
  logic plain;
  assign c = cfg_in[0];
  assign k = ctl_in[0];
  assign s = status_out[0];
  // every edge is one counting step only with the system clock and no restart
  assign plain = c.run && c.clk_sel == CLK_SEL_SYS && !k.reset && !c.compl_en;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  sequence hit_zero;
    $rose(s.tc) && plain;
  endsequence
  start_load_a: assert property ($rose(c.run) |=> s.count == $past(c.period))
    else $error("no load on start");
  count_down_a: assert property (plain && s.running && $past(c.run) && c.mode == MODE_FREE
    && s.count != 16'h0000 |=> s.count == $past(s.count) - 16'h0001) else $error("no decrement");
  zero_reload_a: assert property (hit_zero ##0 c.mode == MODE_FREE |=> s.count == $past(c.period))
    else $error("no reload at zero");
  tc_once_a: assert property (hit_zero ##0 c.mode != MODE_GATED |=> !s.tc)
    else $error("tc too long");
  oneshot_stop_a: assert property (hit_zero ##0 c.mode == MODE_ONESHOT
    |-> ##[1:2] (!s.running && s.count == 16'h0000)) else $error("one-shot kept going");
  gate_hold_a: assert property (c.run && $past(c.run) && c.mode == MODE_GATED && !k.enable && !k.reset
    |=> $stable(s.count)) else $error("gated count moved");
  capture_latch_a: assert property ($rose(k.capture) |=> s.capture == $past(s.count))
    else $error("bad capture");
  kill_force_a: assert property (k.kill |=> !s.cmp) else $error("kill ignored");
  compl_apart_a: assert property ($past(cfg_in[3].compl_en) |-> !(status_out[3].cmp && status_out[3].tc))
    else $error("complementary outputs overlap");
endmodule : timer_counter_pwm_16bit_asserts
bind timer_counter_pwm_16bit timer_counter_pwm_16bit_asserts u_chk (.clock_in(clock_in),
  .resetn_in(resetn_in), .cfg_in(cfg_in), .ctl_in(ctl_in), .ext_tick_in(ext_tick_in), .status_out(status_out));
`default_nettype wire

// ---- timer_counter_pwm_16bit_test.sv ----
// self-checking bench for the four-channel timer unit
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_16bit_test;
  import timer_counter_pwm_pkg::*;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  chan_cfg_t [3:0] cfg = '0;
  chan_ctl_t [3:0] req = '0;
  chan_ctl_t [3:0] ctl;
  chan_status_t [3:0] st;
  logic [3:0][7:0] irqs;
  logic [3:0] tick_pin = '0;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clock_in = ~clock_in;
  timer_counter_pwm_16bit u_dut (.clock_in(clock_in), .resetn_in(resetn_in), .cfg_in(cfg),
    .ctl_in(ctl), .ext_tick_in(tick_pin), .status_out(st));
  fabric_model u_fab (.clock_in(clock_in), .resetn_in(resetn_in), .req_in(req), .status_in(st),
    .ctl_out(ctl), .irq_count_out(irqs));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_in);
    @(negedge clock_in);
  endtask : wait_n
  // run low for one edge first so the start is a real rising edge
  task automatic start(input int ch, input logic [1:0] md, input logic [15:0] per, input logic [1:0] cs);
    @(posedge clock_in);
    cfg[ch] <= '{1'b0, md, cs, CMP_EQUAL, 3'h5, 1'b0, 8'h00, per, 16'h0005};
    @(posedge clock_in);
    cfg[ch].run <= 1'b1;
  endtask : start
  task automatic t_free;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      start(ch, MODE_FREE, 16'h0003, CLK_SEL_SYS);
      wait_n(1);
      check(st[ch].count, 16'h0003);
      wait_n(1);
      check(st[ch].count, 16'h0002);
    end
    wait_n(2);
    check(st[3].count, 16'h0000);
    check(16'(st[3].tc), 16'h0001);
    wait_n(1);
    check(16'(st[3].tc), 16'h0000);
    check(st[3].count, 16'h0003);
    wait_n(2);
    check(16'(irqs[3]), 16'h0001);
  endtask : t_free
  task automatic t_one;
    start(0, MODE_ONESHOT, 16'h0002, CLK_SEL_SYS);
    wait_n(8);
    check(16'(st[0].running), 16'h0000);
    check(st[0].count, 16'h0000);
  endtask : t_one
  task automatic t_gate;
    logic [7:0] n0;
    logic [4:0] want = 5'b01110;
    start(0, MODE_GATED, 16'h0005, CLK_SEL_SYS);
    wait_n(3);
    check(st[0].count, 16'h0005);
    for (int m = 0; m < 5; m++) begin
      @(posedge clock_in);
      cfg[0].cmp_mode <= 3'(m);
      wait_n(2);
      check(16'(st[0].cmp), 16'(want[m]));
    end
    @(posedge clock_in);
    cfg[0].cmp_mode <= CMP_EQUAL;
    req[0].kill <= 1'b1;
    wait_n(3);
    check(16'(st[0].cmp), 16'h0000);
    n0 = irqs[0];
    @(posedge clock_in);
    req[0].kill <= 1'b0;
    req[0].capture <= 1'b1;
    wait_n(4);
    check(16'(st[0].cmp), 16'h0001);
    check(st[0].capture, 16'h0005);
    check(16'(irqs[0] - n0), 16'h0001);
    @(posedge clock_in);
    req[0].capture <= 1'b0;
    req[0].enable <= 1'b1;
    @(posedge clock_in);
    req[0].enable <= 1'b0;
    wait_n(3);
    check(st[0].count, 16'h0004);
    @(posedge clock_in);
    req[0].reset <= 1'b1;
    @(posedge clock_in);
    req[0].reset <= 1'b0;
    wait_n(3);
    check(st[0].count, 16'h0005);
  endtask : t_gate
  // any 8 clocks hold two divide-by-4 ticks, any 64 clocks one divide-by-64 tick
  task automatic t_clock;
    start(1, MODE_FREE, 16'h0010, CLK_SEL_DIV4);
    wait_n(9);
    check(st[1].count, 16'h000e);
    start(2, MODE_FREE, 16'h0010, CLK_SEL_EXT);
    repeat (3) begin
      @(posedge clock_in);
      tick_pin[2] <= 1'b1;
      repeat (2) @(posedge clock_in);
      tick_pin[2] <= 1'b0;
      @(posedge clock_in);
    end
    wait_n(5);
    check(st[2].count, 16'h000d);
    start(1, MODE_FREE, 16'h0010, CLK_SEL_DIV64);
    wait_n(65);
    check(st[1].count, 16'h000f);
  endtask : t_clock
  task automatic t_dead;
    start(3, MODE_GATED, 16'h0005, CLK_SEL_SYS);
    wait_n(3);
    @(posedge clock_in);
    cfg[3] <= '{1'b1, MODE_GATED, CLK_SEL_SYS, CMP_EQUAL, 3'h5, 1'b1, 8'h03, 16'h0005, 16'h0005};
    wait_n(1);
    check(16'(st[3].cmp), 16'h0001);
    check(16'(st[3].tc), 16'h0000);
    @(posedge clock_in);
    req[3].enable <= 1'b1;
    @(posedge clock_in);
    req[3].enable <= 1'b0;
    wait_n(2);
    check(st[3].count, 16'h0004);
    check(16'(st[3].cmp), 16'h0000);
    check(16'(st[3].tc), 16'h0000);
    wait_n(2);
    check(16'(st[3].tc), 16'h0000);
    wait_n(1);
    check(16'(st[3].tc), 16'h0001);
    check(16'(st[3].cmp), 16'h0000);
    @(posedge clock_in);
    req[3].kill <= 1'b1;
    wait_n(2);
    check(16'(st[3].tc), 16'h0000);
    @(posedge clock_in);
    req[3].kill <= 1'b0;
  endtask : t_dead
  task automatic test_done;
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // the whole run needs a few hundred cycles at most
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_free();
    t_one();
    t_gate();
    t_clock();
    t_dead();
    test_done();
  end
endmodule : timer_counter_pwm_16bit_test
`default_nettype wire

// ---- timer_counter_pwm_pkg.sv ----
// shared constants and types for the four-channel 16-bit down-counting timer/counter/pwm
package timer_counter_pwm_pkg;
  localparam int NUM_CH = 4;
  localparam int CNT_W = 16;
  localparam int DB_W = 8;
  localparam int DIV_W = 6;
  // clock source selection
  localparam logic [1:0] CLK_SEL_SYS = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV4 = 2'h1;
  localparam logic [1:0] CLK_SEL_DIV64 = 2'h2;
  localparam logic [1:0] CLK_SEL_EXT = 2'h3;
  localparam logic [DIV_W-1:0] DIV4_LAST = 6'h03;
  localparam logic [DIV_W-1:0] DIV4_MASK = 6'h03;
  localparam logic [DIV_W-1:0] DIV64_LAST = 6'h3f;
  // run modes
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_GATED = 2'h2;
  // comparator conditions
  localparam logic [2:0] CMP_LESS = 3'h0;
  localparam logic [2:0] CMP_LESS_EQUAL = 3'h1;
  localparam logic [2:0] CMP_EQUAL = 3'h2;
  localparam logic [2:0] CMP_GREATER_EQUAL = 3'h3;
  localparam logic [2:0] CMP_GREATER = 3'h4;
  // irq source mask bit positions
  localparam int IRQ_TC_BIT = 0;
  localparam int IRQ_CMP_BIT = 1;
  localparam int IRQ_CAP_BIT = 2;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

  typedef struct packed {
    logic run;                 // software enable; rising edge is the start
    logic [1:0] mode;
    logic [1:0] clk_sel;
    logic [2:0] cmp_mode;
    logic [2:0] irq_mask;
    logic compl_en;            // tc output becomes complementary pwm
    logic [DB_W-1:0] deadband; // dead time in system clocks
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] compare;
  } chan_cfg_t;

  typedef struct packed {
    logic enable;
    logic reset;
    logic capture;
    logic kill;
  } chan_ctl_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] capture;
    logic running;
    logic cmp;
    logic tc;
    logic irq;
  } chan_status_t;
endpackage : timer_counter_pwm_pkg
